// *** verilog/tap_pkg.sv ***
// Constants, codes and state types of the boundary-scan test port
package tap_pkg;

    // ------------------------------------------------------------------
    // Scan path lengths
    // ------------------------------------------------------------------
    localparam int IR_LEN  = 3;
    localparam int ID_LEN  = 32;
    localparam int BSR_LEN = 107;
    localparam int OE_CELL = 47;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [IR_LEN-1:0] INSTR_EXTEST  = 3'h0;
    localparam logic [IR_LEN-1:0] INSTR_IDCODE  = 3'h1;
    localparam logic [IR_LEN-1:0] INSTR_SAMPLEZ = 3'h2;
    localparam logic [IR_LEN-1:0] INSTR_SAMPLE  = 3'h4;
    localparam logic [IR_LEN-1:0] INSTR_BYPASS  = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE    = 3'h1;

    // ------------------------------------------------------------------
    // Identification word fields (values arbitrary)
    // ------------------------------------------------------------------
    localparam int ID_REV_HI    = 31;
    localparam int ID_REV_LO    = 29;
    localparam int ID_PART_HI   = 28;
    localparam int ID_PART_LO   = 12;
    localparam int ID_VENDOR_HI = 11;
    localparam int ID_VENDOR_LO = 1;
    localparam int ID_PRES_BIT  = 0;
    localparam logic [2:0]  ID_REV     = 3'h0;
    localparam logic [16:0] ID_PART    = 17'h0_1234;
    localparam logic [10:0] ID_VENDOR  = 11'h055;
    localparam logic        ID_PRESENT = 1'h1;
    localparam logic [ID_LEN-1:0] ID_WORD =
        {ID_REV, ID_PART, ID_VENDOR, ID_PRESENT};

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [BSR_LEN-1:0] BSR_RESET =
        {{(BSR_LEN-OE_CELL-1){1'h0}}, 1'h1, {OE_CELL{1'h0}}};
    localparam logic BYPASS_CAPTURE = 1'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR     = 4'h0,
        RTI     = 4'h1,
        SEL_DR  = 4'h3,
        CAP_DR  = 4'h2,
        SH_DR   = 4'h6,
        EX1_DR  = 4'h7,
        PAU_DR  = 4'h5,
        EX2_DR  = 4'h4,
        UPD_DR  = 4'hc,
        SEL_IR  = 4'hd,
        CAP_IR  = 4'hf,
        SH_IR   = 4'he,
        EX1_IR  = 4'ha,
        PAU_IR  = 4'hb,
        EX2_IR  = 4'h9,
        UPD_IR  = 4'h8
    } tap_state_type;

    typedef enum logic [1:0] {
        DRIVE_NORMAL = 2'h0,
        DRIVE_HIZ    = 2'h1,
        DRIVE_FORCED = 2'h3
    } drive_mode_type;

endpackage

// *** verilog/tap_ctl_if.sv ***
// Controller phase signals passed from the state machine to the scan core
`timescale 1ns/1ps
interface tap_ctl_if;
    logic tlr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;

    modport fsm (
        output tlr, capture_ir, shift_ir, update_ir,
        output capture_dr, shift_dr, update_dr
    );
    modport core (
        input  tlr, capture_ir, shift_ir, update_ir,
        input  capture_dr, shift_dr, update_dr
    );
endinterface

// *** verilog/sync2.sv ***
// Two-flop level synchroniser with asynchronous clear
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,   // Destination clock
    input  wire logic             rst_b_i, // Async reset, active low
    input  wire logic [WIDTH-1:0] d_i,     // Level from other domain
    output logic      [WIDTH-1:0] q_o      // Synchronised level
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// *** verilog/tap_fsm.sv ***
// Sixteen-state test port controller on the test clock
`timescale 1ns/1ps
module tap_fsm
    import tap_pkg::*;
(
    input  wire logic   tck_i,   // Test clock
    input  wire logic   rst_b_i, // Test-domain reset, active low
    input  wire logic   tms_i,   // Mode select
    tap_ctl_if.fsm      ctl      // Phase signals
);
    tap_state_type state_reg;
    tap_state_type state_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TLR:    state_next = tms_i ? TLR    : RTI;
            RTI:    state_next = tms_i ? SEL_DR : RTI;
            SEL_DR: state_next = tms_i ? SEL_IR : CAP_DR;
            CAP_DR: state_next = tms_i ? EX1_DR : SH_DR;
            SH_DR:  state_next = tms_i ? EX1_DR : SH_DR;
            EX1_DR: state_next = tms_i ? UPD_DR : PAU_DR;
            PAU_DR: state_next = tms_i ? EX2_DR : PAU_DR;
            EX2_DR: state_next = tms_i ? UPD_DR : SH_DR;
            UPD_DR: state_next = tms_i ? SEL_DR : RTI;
            SEL_IR: state_next = tms_i ? TLR    : CAP_IR;
            CAP_IR: state_next = tms_i ? EX1_IR : SH_IR;
            SH_IR:  state_next = tms_i ? EX1_IR : SH_IR;
            EX1_IR: state_next = tms_i ? UPD_IR : PAU_IR;
            PAU_IR: state_next = tms_i ? EX2_IR : PAU_IR;
            EX2_IR: state_next = tms_i ? UPD_IR : SH_IR;
            UPD_IR: state_next = tms_i ? SEL_DR : RTI;
            default: state_next = TLR;
        endcase
    end

    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= TLR;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ctl.tlr        = (state_reg == TLR);
    assign ctl.capture_ir = (state_reg == CAP_IR);
    assign ctl.shift_ir   = (state_reg == SH_IR);
    assign ctl.update_ir  = (state_reg == UPD_IR);
    assign ctl.capture_dr = (state_reg == CAP_DR);
    assign ctl.shift_dr   = (state_reg == SH_DR);
    assign ctl.update_dr  = (state_reg == UPD_DR);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    five_ones_a: assert property (
        @(posedge tck_i) disable iff (!rst_b_i)
        tms_i [*5] |=> (state_reg == TLR))
        else $error("five high mode bits did not reach reset state");

    tms_step_a: assert property (
        @(posedge tck_i) disable iff (!rst_b_i)
        (state_reg == RTI) && tms_i |=> (state_reg == SEL_DR))
        else $error("mode select not sampled on rising edge");
endmodule

// *** verilog/tap_top.sv ***
// Boundary-scan test port of the burst memory with data output gating
`timescale 1ns/1ps
module tap_top
    import tap_pkg::*;
(
    input  wire logic               clk_i,     // Memory clock
    input  wire logic               rst_b_i,   // Async reset, active low
    input  wire logic               tck_i,     // Test clock
    input  wire logic               tms_i,     // Test mode select
    input  wire logic               tdi_i,     // Serial data in
    input  wire logic [BSR_LEN-1:0] ring_i,    // Pin ring values
    input  wire logic               mem_oe_i,  // Core output enable request
    output logic                    tdo_o,     // Serial data out
    output logic                    tdo_oe_o,  // Serial out driven
    output logic                    q_oe_o,    // Data output drivers enable
    output logic [BSR_LEN-1:0]      bsr_upd_o, // Boundary update latches
    output logic                    extest_o   // External test active
);
    // ------------------------------------------------------------------
    // Test-domain reset and controller
    // ------------------------------------------------------------------
    logic tck_rst_b;
    tap_ctl_if ctl ();

    sync2 #(
        .WIDTH (1)
    ) u_tck_rst (
        .clk_i   (tck_i),
        .rst_b_i (rst_b_i),
        .d_i     (1'h1),
        .q_o     (tck_rst_b)
    );

    tap_fsm u_fsm (
        .tck_i   (tck_i),
        .rst_b_i (tck_rst_b),
        .tms_i   (tms_i),
        .ctl     (ctl.fsm)
    );

    // ------------------------------------------------------------------
    // Ring values into the test domain
    // ------------------------------------------------------------------
    logic [BSR_LEN-1:0] ring_s;

    sync2 #(
        .WIDTH (BSR_LEN)
    ) u_ring_sync (
        .clk_i   (tck_i),
        .rst_b_i (tck_rst_b),
        .d_i     (ring_i),
        .q_o     (ring_s)
    );

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    logic [IR_LEN-1:0] ir_sh_reg;
    logic [IR_LEN-1:0] instr_reg;

    function automatic logic bsr_sel(input logic [IR_LEN-1:0] code);
        return (code == INSTR_EXTEST) || (code == INSTR_SAMPLEZ) ||
               (code == INSTR_SAMPLE);
    endfunction

    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            ir_sh_reg <= IR_CAPTURE;
        end else if (ctl.capture_ir) begin
            ir_sh_reg <= IR_CAPTURE;
        end else if (ctl.shift_ir) begin
            ir_sh_reg <= {tdi_i, ir_sh_reg[IR_LEN-1:1]};
        end
    end

    // Reserved codes are kept as loaded; they select the bypass path
    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            instr_reg <= INSTR_IDCODE;
        end else if (ctl.tlr) begin
            instr_reg <= INSTR_IDCODE;
        end else if (ctl.update_ir) begin
            instr_reg <= ir_sh_reg;
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic               byp_reg;
    logic [ID_LEN-1:0]  id_sh_reg;
    logic [BSR_LEN-1:0] bsr_sh_reg;
    logic               sel_bsr;
    logic               sel_id;

    assign sel_bsr = bsr_sel(instr_reg);
    assign sel_id  = (instr_reg == INSTR_IDCODE);

    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            byp_reg <= BYPASS_CAPTURE;
        end else if (ctl.capture_dr) begin
            byp_reg <= BYPASS_CAPTURE;
        end else if (ctl.shift_dr) begin
            byp_reg <= tdi_i;
        end
    end

    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            id_sh_reg <= ID_WORD;
        end else if (ctl.capture_dr && sel_id) begin
            id_sh_reg <= ID_WORD;
        end else if (ctl.shift_dr && sel_id) begin
            id_sh_reg <= {tdi_i, id_sh_reg[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            bsr_sh_reg <= BSR_RESET;
        end else if (ctl.capture_dr && sel_bsr) begin
            bsr_sh_reg <= ring_s;
        end else if (ctl.shift_dr && sel_bsr) begin
            bsr_sh_reg <= {tdi_i, bsr_sh_reg[BSR_LEN-1:1]};
        end
    end

    // Update latches; output-gating cell preset in reset state
    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            bsr_upd_o <= BSR_RESET;
        end else if (ctl.tlr) begin
            bsr_upd_o <= BSR_RESET;
        end else if (ctl.update_dr && sel_bsr) begin
            bsr_upd_o <= bsr_sh_reg;
        end
    end

    // ------------------------------------------------------------------
    // Serial output on the falling edge
    // ------------------------------------------------------------------
    always_ff @(negedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            tdo_o    <= 1'h0;
            tdo_oe_o <= 1'h0;
        end else begin
            tdo_oe_o <= ctl.shift_ir || ctl.shift_dr;
            if (ctl.shift_ir) begin
                tdo_o <= ir_sh_reg[0];
            end else if (ctl.shift_dr) begin
                if (sel_bsr) begin
                    tdo_o <= bsr_sh_reg[0];
                end else if (sel_id) begin
                    tdo_o <= id_sh_reg[0];
                end else begin
                    tdo_o <= byp_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output driver mode, decided on the test clock
    // ------------------------------------------------------------------
    drive_mode_type mode_reg;

    always_ff @(posedge tck_i or negedge tck_rst_b) begin
        if (!tck_rst_b) begin
            mode_reg <= DRIVE_NORMAL;
            extest_o <= 1'h0;
        end else begin
            extest_o <= (instr_reg == INSTR_EXTEST);
            if (instr_reg == INSTR_SAMPLEZ) begin
                mode_reg <= DRIVE_HIZ;
            end else if (instr_reg == INSTR_EXTEST) begin
                mode_reg <= bsr_upd_o[OE_CELL] ? DRIVE_FORCED : DRIVE_HIZ;
            end else begin
                mode_reg <= DRIVE_NORMAL;
            end
        end
    end

    // ------------------------------------------------------------------
    // Driver enable in the memory clock domain
    // ------------------------------------------------------------------
    logic [1:0] mode_s;

    sync2 #(
        .WIDTH (2)
    ) u_mode_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (mode_reg),
        .q_o     (mode_s)
    );

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_oe_o <= 1'h0;
        end else begin
            case (mode_s)
                DRIVE_HIZ:    q_oe_o <= 1'h0;
                DRIVE_FORCED: q_oe_o <= 1'h1;
                default:      q_oe_o <= mem_oe_i;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ir_update_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.update_ir |=> instr_reg == $past(ir_sh_reg))
        else $error("instruction not taken at update");

    reset_idcode_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.tlr |=> instr_reg == INSTR_IDCODE)
        else $error("reset state did not select identification");

    oe_preset_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.tlr |=> bsr_upd_o[OE_CELL])
        else $error("output gating cell not preset");

    id_capture_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.capture_dr && sel_id |=>
            id_sh_reg[ID_PRES_BIT] &&
            id_sh_reg[ID_VENDOR_HI:ID_VENDOR_LO] == ID_VENDOR &&
            id_sh_reg[ID_PART_HI:ID_PART_LO] == ID_PART &&
            id_sh_reg[ID_REV_HI:ID_REV_LO] == ID_REV)
        else $error("identification word wrong at capture");

    bypass_capture_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.capture_dr && instr_reg == INSTR_BYPASS |=>
            byp_reg == BYPASS_CAPTURE)
        else $error("bypass cell not cleared at capture");

    bypass_path_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.shift_dr && instr_reg == INSTR_BYPASS |=>
            byp_reg == $past(tdi_i))
        else $error("bypass cell wrong");

    tdo_enable_a: assert property (
        @(negedge tck_i) disable iff (!tck_rst_b)
        ctl.shift_ir || ctl.shift_dr |=> tdo_oe_o)
        else $error("serial output not enabled while shifting");

    bsr_capture_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.capture_dr && sel_bsr |=> bsr_sh_reg == $past(ring_s))
        else $error("boundary register missed ring capture");

    bsr_shift_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.shift_dr && sel_bsr |=>
            bsr_sh_reg[BSR_LEN-1] == $past(tdi_i) &&
            bsr_sh_reg[BSR_LEN-2:0] == $past(bsr_sh_reg[BSR_LEN-1:1]))
        else $error("boundary register did not shift");

    hiz_output_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode_s == DRIVE_HIZ |=> !q_oe_o)
        else $error("outputs driven while forced off");

    normal_output_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode_s == DRIVE_NORMAL |=> q_oe_o == $past(mem_oe_i))
        else $error("output enable disturbed in normal mode");

    samplez_mode_a: assert property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        instr_reg == INSTR_SAMPLEZ [*2] |-> mode_reg == DRIVE_HIZ)
        else $error("high impedance mode not selected");

    id_shift_c: cover property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.shift_dr && sel_id);

    samplez_c: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode_s == DRIVE_HIZ);

    extest_drive_c: cover property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode_s == DRIVE_FORCED);

    bypass_c: cover property (
        @(posedge tck_i) disable iff (!tck_rst_b)
        ctl.shift_dr && instr_reg == INSTR_BYPASS);
endmodule

// *** test/scan_ctl_model.sv ***
// Behavioural boundary-scan test controller that drives the link
`timescale 1ns/1ps
module scan_ctl_model
    import tap_pkg::*;
(
    output logic      tck_o, // Test clock, still outside frames
    output logic      tms_o, // Mode select
    output logic      tdi_o, // Serial data in
    input  wire logic tdo_i  // Serial data out from the port
);
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end

    // ------------------------------------------------------------------
    // Link cycles
    // ------------------------------------------------------------------
    // One 80 ns period; inputs move only while the clock is low
    task automatic cycle(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #20;
        tdo = tdo_i;
        tck_o = 1'h1;
        #40;
        tck_o = 1'h0;
        #20;
    endtask

    // Mode steps, least significant first; idle data line toggles
    task automatic walk(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            cycle(seq[i], ~tdi_o, d);
        end
    endtask

    // Five ones reach reset from any state, then idle
    task automatic reset_tlr();
        walk(8'h1f, 6);
    endtask

    // Only four of the five defined codes are ever loaded by the bench; IDCODE is never loaded
    task automatic load_ir(input  logic [IR_LEN-1:0] code,
                           output logic [IR_LEN-1:0] cap);
        walk(8'h03, 4);
        for (int i = 0; i < IR_LEN; i++) begin
            cycle(i == IR_LEN-1, code[i], cap[i]);
        end
        walk(8'h01, 4);
    endtask

    task automatic shift_dr(input  int                 n,
                            input  logic [BSR_LEN-1:0] din,
                            output logic [BSR_LEN-1:0] dout);
        dout = '0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            cycle(i == n-1, din[i], dout[i]);
        end
        walk(8'h01, 4);
    endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb
    import tap_pkg::*;
();
    localparam logic [BSR_LEN-1:0] RING_PAT =
        {11'h5a3, 32'hc0de_1f2e, 32'h8b4d_7a69, 32'h3e5c_0f91};
    localparam logic [BSR_LEN-1:0] PRE_OFF = ~RING_PAT & ~BSR_RESET;
    localparam logic [BSR_LEN-1:0] PRE_ON  = PRE_OFF | BSR_RESET;

    logic               clk_i;
    logic               rst_b_i;
    logic               tck_i;
    logic               tms_i;
    logic               tdi_i;
    logic [BSR_LEN-1:0] ring_i;
    logic               mem_oe_i;
    logic               tdo_o;
    logic               tdo_oe_o;
    logic               q_oe_o;
    logic [BSR_LEN-1:0] bsr_upd_o;
    logic               extest_o;
    int                 fails;
    int                 checks;
    logic [BSR_LEN-1:0] dout;
    logic [IR_LEN-1:0]  cap;

    tap_top i_tap_top (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .tck_i     (tck_i),
        .tms_i     (tms_i),
        .tdi_i     (tdi_i),
        .ring_i    (ring_i),
        .mem_oe_i  (mem_oe_i),
        .tdo_o     (tdo_o),
        .tdo_oe_o  (tdo_oe_o),
        .q_oe_o    (q_oe_o),
        .bsr_upd_o (bsr_upd_o),
        .extest_o  (extest_o)
    );

    scan_ctl_model i_scan_ctl_model (
        .tck_o (tck_i),
        .tms_o (tms_i),
        .tdi_o (tdi_i),
        .tdo_i (tdo_o)
    );

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [BSR_LEN-1:0] seen,
                         input logic [BSR_LEN-1:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check1(input string name, input logic seen,
                          input logic exp);
        check(name, BSR_LEN'(seen), BSR_LEN'(exp));
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic set_oe(input logic v);
        wait_clk(1);
        mem_oe_i = v;
        wait_clk(6);
    endtask

    task automatic load(input logic [IR_LEN-1:0] code);
        i_scan_ctl_model.load_ir(code, cap);
        check("ir_capture", BSR_LEN'(cap), BSR_LEN'(IR_CAPTURE));
        check1("tdo_oe_idle", tdo_oe_o, 1'h0);
        wait_clk(6);
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_idcode();
        check("bsr_upd_reset", bsr_upd_o, BSR_RESET);
        check1("extest_reset", extest_o, 1'h0);
        i_scan_ctl_model.shift_dr(ID_LEN, '0, dout);
        check("id_word", BSR_LEN'(dout[ID_LEN-1:0]),
              BSR_LEN'(ID_WORD));
        set_oe(1'h1);
        check1("q_oe_idcode_on", q_oe_o, 1'h1);
        set_oe(1'h0);
        check1("q_oe_idcode_off", q_oe_o, 1'h0);
    endtask

    task automatic test_bypass();
        load(INSTR_BYPASS);
        i_scan_ctl_model.shift_dr(8, BSR_LEN'(8'hb4), dout);
        check("bypass_path", BSR_LEN'(dout[7:0]),
              BSR_LEN'({7'h34, BYPASS_CAPTURE}));
        set_oe(1'h1);
        check1("q_oe_bypass", q_oe_o, 1'h1);
    endtask

    task automatic test_sample();
        ring_i = RING_PAT;
        load(INSTR_SAMPLE);
        i_scan_ctl_model.shift_dr(BSR_LEN, PRE_OFF, dout);
        check("sample_capture", dout, RING_PAT);
        check("sample_preload", bsr_upd_o, PRE_OFF);
        wait_clk(6);
        check1("q_oe_sample", q_oe_o, 1'h1);
    endtask

    task automatic test_samplez();
        ring_i = ~RING_PAT;
        load(INSTR_SAMPLEZ);
        check1("q_oe_hiz", q_oe_o, 1'h0);
        i_scan_ctl_model.shift_dr(BSR_LEN, PRE_OFF, dout);
        check("samplez_capture", dout, ~RING_PAT);
    endtask

    task automatic test_extest();
        set_oe(1'h1);
        load(INSTR_EXTEST);
        check1("extest_on", extest_o, 1'h1);
        check1("q_oe_cell_low", q_oe_o, 1'h0);
        i_scan_ctl_model.shift_dr(BSR_LEN, PRE_ON, dout);
        check("extest_capture", dout, ~RING_PAT);
        set_oe(1'h0);
        check1("q_oe_cell_high", q_oe_o, 1'h1);
        i_scan_ctl_model.reset_tlr();
        check("bsr_upd_tlr", bsr_upd_o, BSR_RESET);
        check1("extest_tlr", extest_o, 1'h0);
        i_scan_ctl_model.shift_dr(ID_LEN, '0, dout);
        check("id_after_tlr", BSR_LEN'(dout[ID_LEN-1:0]),
              BSR_LEN'(ID_WORD));
        wait_clk(6);
        check1("q_oe_after_tlr", q_oe_o, 1'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fails = 0;
        checks = 0;
        rst_b_i = 1'h0;
        mem_oe_i = 1'h0;
        ring_i = '0;
        fork
            repeat (20) @(posedge clk_i);
            i_scan_ctl_model.walk(8'hff, 2);
        join
        #1;
        rst_b_i = 1'h1;
        i_scan_ctl_model.reset_tlr();
        test_idcode();
        test_bypass();
        test_sample();
        test_samplez();
        test_extest();
        complete_run();
    end

    initial begin
        #200us;
        fails++;
        complete_run();
    end
endmodule
